// *** common/sflash_consts.svh ***
// constants of the serial flash command decoder: opcodes, counts, reset values
// assumes: included by bare name from packages and modules that need them
`ifndef SFLASH_CONSTS_SVH
`define SFLASH_CONSTS_SVH

// ****************************************
// opcodes
// ****************************************
`define OP_WL_SET 8'h06
`define OP_WL_CLR 8'h04
`define OP_JEDEC 8'h9f
`define OP_STAT_RD 8'h05
`define OP_STAT_WR 8'h01
`define OP_READ 8'h03
`define OP_FAST 8'h0b
`define OP_DUAL 8'hbb
`define OP_QUAD 8'heb
`define OP_WQUAD 8'he7
`define OP_PROG 8'h02
`define OP_QPROG 8'h38
`define OP_WIPE4K 8'h20
`define OP_WIPE32K 8'h52
`define OP_WIPE64K 8'hd8
`define OP_CHIP_A 8'h60
`define OP_CHIP_B 8'hc7
`define OP_SLEEP 8'hb9
`define OP_WAKE 8'hab
`define OP_MDID 8'h90
`define OP_SEC_RD 8'h2b
`define OP_SEC_WR 8'h2f

// ****************************************
// link clock limits in mhz (host side)
// ****************************************
`define FREQ_READ_MHZ 33
`define FREQ_FAST_MHZ 104
`define FREQ_SLOW_MHZ 84

// ****************************************
// dummy and mode edge counts, address and byte bit counts
// ****************************************
`define DUMMY_SLOW 5'h04
`define DUMMY_FAST 5'h06
`define DUMMY_FAST_SPI 5'h08
`define DUMMY_DUAL 5'h04
`define DUMMY_WQUAD 5'h04
`define MODE_EDGES 5'h02
`define ADDR_BITS 5'h18
`define BYTE_BITS 5'h08

// ****************************************
// status, security and identity
// ****************************************
`define ST_BUSY 0
`define ST_WEL 1
`define STATUS_RESET 8'h00
`define SEC_RESET 8'h00
`define SEC_LOCK 1
`define ERASED_BYTE 8'hff
`define MDID_DEV_FIRST 1'h1

// ****************************************
// power-up timing
// ****************************************
`define CORE_CLK_MHZ 100
`define VSL_MIN_US 300
`define PUW_MIN_MS 1
`define PUW_MAX_MS 10
`define PUW_CYCLES (`PUW_MAX_MS * 1000 * `CORE_CLK_MHZ)

`endif

// *** common/sflash_pkg.sv ***
// types of the serial flash command decoder
// assumes: compiled before the design module
package sflash_pkg;

    typedef enum logic [4:0] {
        C_NONE, C_WL_SET, C_WL_CLR, C_JEDEC, C_STAT_RD, C_STAT_WR, C_READ, C_FAST,
        C_DUAL, C_QUAD, C_WQUAD, C_PROG, C_QPROG, C_WIPE4K, C_WIPE32K, C_WIPE64K,
        C_CHIP, C_SLEEP, C_WAKE, C_MDID, C_SEC_RD, C_SEC_WR
    } cmd_e;

    typedef enum logic [5:0] {
        LS_OPC = 6'b000001,
        LS_ADDR = 6'b000010,
        LS_DUMMY = 6'b000100,
        LS_DIN = 6'b001000,
        LS_DOUT = 6'b010000,
        LS_IGNORE = 6'b100000
    } link_state_e;

    typedef enum logic [2:0] {SRC_ARRAY, SRC_STATUS, SRC_JEDEC, SRC_SIG, SRC_MDID, SRC_SEC} src_e;

    typedef struct packed {
        cmd_e cmd;
        logic [23:0] addr;
    } cmd_bus_s;

    typedef struct packed {
        logic [23:0] addr;
        logic [7:0] data;
    } prog_s;

    typedef struct packed {
        logic [3:0] dq;
        logic [3:0] oe;
    } pins_s;

    typedef struct packed {
        link_state_e st;
        logic live;
        logic [2:0] lanes;
        logic [4:0] cnt;
        logic [23:0] sh;
        cmd_e cmd;
        src_e src;
        logic [2:0] pos;
        logic [1:0] idx;
    } link_frame_s;

    typedef struct packed {
        logic done;
        cmd_e cmd;
        logic [23:0] addr;
        logic [7:0] data;
        logic [23:0] paddr;
        logic prog_tgl;
        logic req_tgl;
        logic [23:0] req_addr;
        logic cont;
    } link_held_s;

    typedef struct packed {
        logic [1:0] cs_sync;
        logic cs_prev;
        logic [2:0] req_sync;
        logic [2:0] prog_sync;
        logic rd_pend;
        logic [7:0] reply;
        logic [7:0] status;
        logic [7:0] sec;
        logic deep;
        logic powered;
        logic [31:0] puw_cnt;
        logic pub_qpi;
        logic pub_deep;
        logic [7:0] pub_stat;
        logic [7:0] pub_sec;
        logic cmd_valid;
        cmd_bus_s cmd_bus;
        logic arr_rd;
        logic [23:0] arr_addr;
        logic prog_valid;
        prog_s prog;
    } core_s;

endpackage : sflash_pkg

// *** logic/sflash_cmd_decoder.sv ***
// serial flash command decoder: link side on the host's serial clock, core side on core_clk_i
// assumes: the array lives outside and answers arr_rd_o one core cycle later on arr_data_i;
// the serial clock runs only while selected and its half period spans at least 8 core cycles
`timescale 1ns/10ps
`include "sflash_consts.svh"

module sflash_cmd_decoder
    import sflash_pkg::*;
#(
    parameter logic [4:0] DUMMY_CYCLES = `DUMMY_FAST,
    parameter int PUW_CYCLES = `PUW_CYCLES,
    // identity values are arbitrary
    parameter logic [7:0] MAKER_ID = 8'h5a,
    parameter logic [7:0] MEM_TYPE = 8'h3c,
    parameter logic [7:0] DENSITY = 8'h15,
    parameter logic [7:0] DEVICE_ID = 8'h35,
    parameter logic [7:0] SIG_ID = 8'h34
) (
    // clocks and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic sclk_i,
    // serial link
    input wire logic cs_n_i,
    input wire logic [3:0] dq_i,
    output logic [3:0] dq_o,
    output logic [3:0] dq_oe_o,
    // core configuration and state
    input wire logic four_wire_command_mode_i,
    input wire logic busy_i,
    output logic [7:0] status_o,
    output logic deep_sleep_o,
    output logic write_ready_o,
    // array read port
    output logic arr_rd_o,
    output logic [23:0] arr_addr_o,
    input wire logic [7:0] arr_data_i,
    // committed commands and program data
    output logic cmd_valid_o,
    output cmd_bus_s cmd_o,
    output logic prog_valid_o,
    output prog_s prog_o
);

    link_frame_s lf_r, lf_nxt;
    link_held_s lh_r, lh_nxt;
    pins_s pins_r, pins_nxt;
    core_s cr_r, cr_nxt;
    logic link_rst;

    // the frame ends with its own select; sclk may not tick after it
    assign link_rst = rst_i | cs_n_i;

    function automatic cmd_e decode(input logic [7:0] op, input logic q, input logic dp);
        cmd_e c;
        c = C_NONE;
        case (op)
            `OP_WL_SET: c = C_WL_SET;
            `OP_WL_CLR: c = C_WL_CLR;
            `OP_JEDEC: c = q ? C_NONE : C_JEDEC;
            `OP_STAT_RD: c = C_STAT_RD;
            `OP_STAT_WR: c = C_STAT_WR;
            `OP_READ: c = q ? C_NONE : C_READ;
            `OP_FAST: c = C_FAST;
            `OP_DUAL: c = q ? C_NONE : C_DUAL;
            `OP_QUAD: c = C_QUAD;
            `OP_WQUAD: c = q ? C_NONE : C_WQUAD;
            `OP_PROG: c = C_PROG;
            `OP_QPROG: c = q ? C_NONE : C_QPROG;
            `OP_WIPE4K: c = C_WIPE4K;
            `OP_WIPE32K: c = C_WIPE32K;
            `OP_WIPE64K: c = C_WIPE64K;
            `OP_CHIP_A, `OP_CHIP_B: c = C_CHIP;
            `OP_SLEEP: c = C_SLEEP;
            `OP_WAKE: c = C_WAKE;
            `OP_MDID: c = q ? C_NONE : C_MDID;
            `OP_SEC_RD: c = C_SEC_RD;
            `OP_SEC_WR: c = C_SEC_WR;
            default: c = C_NONE;
        endcase
        // asleep, only the wake opcode is heard
        if (dp && (c != C_WAKE)) begin
            c = C_NONE;
        end
        return c;
    endfunction : decode

    function automatic logic [4:0] edges(input logic [4:0] bits, input logic [2:0] ln);
        logic [4:0] e;
        case (ln)
            3'h4: e = bits >> 2;
            3'h2: e = bits >> 1;
            default: e = bits;
        endcase
        return e;
    endfunction : edges

    // ****************************************
    // link side: posedge sclk sequencing
    // ****************************************
    always_comb begin
        link_frame_s f;
        logic [23:0] sh;
        logic last;
        logic start_out;
        f = lf_r;
        sh = '0;
        last = 1'b0;
        start_out = 1'b0;
        lh_nxt = lh_r;
        if (!f.live) begin
            f.live = 1'b1;
            lh_nxt.done = 1'b0;
            if (lh_r.cont) begin
                f.cmd = C_QUAD;
                f.lanes = 3'h4;
                f.st = LS_ADDR;
                f.cnt = edges(`ADDR_BITS, 3'h4);
            end else begin
                f.lanes = cr_r.pub_qpi ? 3'h4 : 3'h1;
                f.st = LS_OPC;
                f.cnt = edges(`BYTE_BITS, f.lanes);
            end
        end
        case (f.lanes)
            3'h4: sh = {f.sh[19:0], dq_i};
            3'h2: sh = {f.sh[21:0], dq_i[1:0]};
            default: sh = {f.sh[22:0], dq_i[0]};
        endcase
        f.sh = sh;
        last = (f.cnt == 5'h01);
        f.cnt = f.cnt - 5'h01;
        case (f.st)
            LS_OPC: begin
                if (last) begin
                    f.cmd = decode(sh[7:0], cr_r.pub_qpi, cr_r.pub_deep);
                    lh_nxt.cmd = f.cmd;
                    f.sh = '0;
                    case (f.cmd)
                        C_DUAL: f.lanes = 3'h2;
                        C_QUAD, C_WQUAD, C_QPROG: f.lanes = 3'h4;
                        default: f.lanes = f.lanes;
                    endcase
                    f.st = LS_ADDR;
                    f.cnt = edges(`ADDR_BITS, f.lanes);
                    case (f.cmd)
                        // drop the rest of the frame
                        C_NONE: f.st = LS_IGNORE;
                        C_WL_SET, C_WL_CLR, C_CHIP, C_SLEEP, C_SEC_WR: begin
                            lh_nxt.done = 1'b1;
                            f.st = LS_IGNORE;
                        end
                        C_WAKE: begin
                            lh_nxt.done = 1'b1;
                            f.src = SRC_SIG;
                            if (cr_r.pub_qpi) begin
                                f.st = LS_IGNORE;
                            end
                        end
                        C_STAT_RD: begin
                            f.src = SRC_STATUS;
                            start_out = 1'b1;
                        end
                        C_SEC_RD: begin
                            f.src = SRC_SEC;
                            start_out = 1'b1;
                        end
                        C_JEDEC: begin
                            f.src = SRC_JEDEC;
                            start_out = 1'b1;
                        end
                        C_STAT_WR: begin
                            f.st = LS_DIN;
                            f.cnt = edges(`BYTE_BITS, f.lanes);
                        end
                        default: f.src = SRC_ARRAY;
                    endcase
                end
            end
            LS_ADDR: begin
                if (last) begin
                    lh_nxt.addr = sh;
                    lh_nxt.paddr = sh;
                    f.st = LS_DUMMY;
                    case (f.cmd)
                        C_WIPE4K, C_WIPE32K, C_WIPE64K: begin
                            lh_nxt.done = 1'b1;
                            f.st = LS_IGNORE;
                        end
                        C_PROG, C_QPROG: begin
                            lh_nxt.done = 1'b1;
                            f.st = LS_DIN;
                            f.cnt = edges(`BYTE_BITS, f.lanes);
                        end
                        C_READ: start_out = 1'b1;
                        C_FAST: f.cnt = cr_r.pub_qpi ? DUMMY_CYCLES : `DUMMY_FAST_SPI;
                        C_DUAL: f.cnt = `DUMMY_DUAL;
                        C_QUAD: f.cnt = DUMMY_CYCLES;
                        C_WQUAD: f.cnt = `DUMMY_WQUAD;
                        C_MDID: begin
                            // address bit 0 picks the first id
                            f.src = SRC_MDID;
                            f.idx = {1'b0, sh[0] == `MDID_DEV_FIRST};
                            start_out = 1'b1;
                        end
                        C_WAKE: start_out = 1'b1;
                        default: f.st = LS_IGNORE;
                    endcase
                end
            end
            LS_DUMMY: begin
                if ((f.cmd == C_QUAD) && (f.cnt == (DUMMY_CYCLES - `MODE_EDGES))) begin
                    lh_nxt.cont = ((sh[7:4] ^ sh[3:0]) == 4'hf);
                end
                if (last) begin
                    start_out = 1'b1;
                end
            end
            LS_DIN: begin
                if (last) begin
                    lh_nxt.data = sh[7:0];
                    f.cnt = edges(`BYTE_BITS, f.lanes);
                    if (f.cmd == C_STAT_WR) begin
                        lh_nxt.done = 1'b1;
                        f.st = LS_IGNORE;
                    end else begin
                        // page wraps on its low byte
                        if (f.idx[0]) begin
                            lh_nxt.paddr = {lh_r.paddr[23:8], lh_r.paddr[7:0] + 8'h01};
                        end
                        f.idx = 2'h1;
                        lh_nxt.prog_tgl = ~lh_r.prog_tgl;
                    end
                end
            end
            LS_DOUT: begin
                if (f.pos == 3'(edges(`BYTE_BITS, f.lanes) - 5'h01)) begin
                    f.pos = '0;
                    if (f.src == SRC_JEDEC) begin
                        f.idx = (f.idx == 2'h2) ? 2'h0 : f.idx + 2'h1;
                    end else begin
                        f.idx = {1'b0, ~f.idx[0]};
                    end
                    lh_nxt.addr = lh_r.addr + 24'h000001;
                    lh_nxt.req_addr = lh_r.addr + 24'h000001;
                    lh_nxt.req_tgl = ~lh_r.req_tgl;
                end else begin
                    f.pos = f.pos + 3'h1;
                end
            end
            default: f.st = LS_IGNORE;
        endcase
        if (start_out) begin
            // the first byte is fetched now and driven on the next falling edge
            f.st = LS_DOUT;
            f.pos = '0;
            lh_nxt.req_addr = lh_nxt.addr;
            lh_nxt.req_tgl = ~lh_r.req_tgl;
        end
        lf_nxt = f;
    end

    always_ff @(posedge sclk_i or posedge link_rst) begin
        if (link_rst) begin
            lf_r <= '{st: LS_IGNORE, cmd: C_NONE, src: SRC_ARRAY, default: '0};
        end else begin
            lf_r <= lf_nxt;
        end
    end

    // survives deselect: carries the finished command to the core side
    always_ff @(posedge sclk_i or posedge rst_i) begin
        if (rst_i) begin
            lh_r <= '{cmd: C_NONE, default: '0};
        end else begin
            lh_r <= lh_nxt;
        end
    end

    // ****************************************
    // link side: falling edge output
    // ****************************************
    always_comb begin
        logic [7:0] b;
        logic [7:0] sl;
        b = '0;
        sl = '0;
        case (lf_r.src)
            SRC_ARRAY: b = cr_r.reply;
            SRC_STATUS: b = cr_r.pub_stat;
            SRC_SEC: b = cr_r.pub_sec;
            SRC_SIG: b = SIG_ID;
            SRC_JEDEC: b = (lf_r.idx == 2'h0) ? MAKER_ID : (lf_r.idx == 2'h1) ? MEM_TYPE : DENSITY;
            SRC_MDID: b = lf_r.idx[0] ? DEVICE_ID : MAKER_ID;
            default: b = `ERASED_BYTE;
        endcase
        sl = b << 6'(lf_r.pos * lf_r.lanes);
        pins_nxt = '0;
        // lines stay released through dummy edges
        if (lf_r.st == LS_DOUT) begin
            case (lf_r.lanes)
                3'h4: pins_nxt = '{dq: sl[7:4], oe: 4'hf};
                3'h2: pins_nxt = '{dq: {2'h0, sl[7:6]}, oe: 4'h3};
                default: pins_nxt = '{dq: {2'h0, sl[7], 1'b0}, oe: 4'h2};
            endcase
        end
    end

    always_ff @(negedge sclk_i or posedge link_rst) begin
        if (link_rst) begin
            pins_r <= '0;
        end else begin
            pins_r <= pins_nxt;
        end
    end

    // ****************************************
    // core side
    // ****************************************
    always_comb begin
        logic cs_rise;
        logic wr_ok;
        cr_nxt = cr_r;
        cr_nxt.cs_sync = {cr_r.cs_sync[0], cs_n_i};
        cr_nxt.cs_prev = cr_r.cs_sync[1];
        cr_nxt.req_sync = {cr_r.req_sync[1:0], lh_r.req_tgl};
        cr_nxt.prog_sync = {cr_r.prog_sync[1:0], lh_r.prog_tgl};
        cr_nxt.cmd_valid = 1'b0;
        cr_nxt.arr_rd = 1'b0;
        cr_nxt.prog_valid = 1'b0;
        cs_rise = cr_r.cs_sync[1] & ~cr_r.cs_prev;
        wr_ok = cr_r.status[`ST_WEL] & cr_r.powered;
        // write-type commands wait out the delay
        if (!cr_r.powered) begin
            cr_nxt.puw_cnt = cr_r.puw_cnt + 32'h1;
            cr_nxt.powered = (cr_r.puw_cnt == 32'(PUW_CYCLES - 1));
        end
        // link-facing copies change only while deselected
        if (cr_r.cs_sync[1]) begin
            cr_nxt.pub_qpi = four_wire_command_mode_i;
            cr_nxt.pub_deep = cr_r.deep;
            cr_nxt.pub_stat = cr_r.status;
            cr_nxt.pub_stat[`ST_BUSY] = busy_i;
            cr_nxt.pub_sec = cr_r.sec;
        end
        if (cr_r.req_sync[2] != cr_r.req_sync[1]) begin
            cr_nxt.arr_rd = 1'b1;
            cr_nxt.arr_addr = lh_r.req_addr;
        end
        // the array answers one cycle after the request pulse
        cr_nxt.rd_pend = cr_r.arr_rd;
        if (cr_r.rd_pend) begin
            cr_nxt.reply = arr_data_i;
        end
        if ((cr_r.prog_sync[2] != cr_r.prog_sync[1]) && wr_ok) begin
            cr_nxt.prog_valid = 1'b1;
            cr_nxt.prog = '{addr: lh_r.paddr, data: lh_r.data};
        end
        if (cs_rise && lh_r.done) begin
            cr_nxt.cmd_bus = '{cmd: lh_r.cmd, addr: lh_r.addr};
            case (lh_r.cmd)
                C_WL_SET: cr_nxt.status[`ST_WEL] = 1'b1;
                C_WL_CLR: cr_nxt.status[`ST_WEL] = 1'b0;
                C_STAT_WR, C_SEC_WR, C_WIPE4K, C_WIPE32K, C_WIPE64K, C_CHIP, C_PROG,
                C_QPROG: begin
                    if (wr_ok) begin
                        cr_nxt.cmd_valid = 1'b1;
                        cr_nxt.status[`ST_WEL] = 1'b0;
                        if (lh_r.cmd == C_STAT_WR) begin
                            cr_nxt.status[7:2] = lh_r.data[7:2];
                        end
                        if (lh_r.cmd == C_SEC_WR) begin
                            cr_nxt.sec[`SEC_LOCK] = 1'b1;
                        end
                    end
                end
                C_SLEEP: begin
                    cr_nxt.deep = 1'b1;
                    cr_nxt.cmd_valid = 1'b1;
                end
                C_WAKE: begin
                    cr_nxt.deep = 1'b0;
                    cr_nxt.cmd_valid = 1'b1;
                end
                default: cr_nxt.cmd_valid = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            // delivery state of status and security bytes
            cr_r <= '{cs_sync: 2'h3, cs_prev: 1'b1, reply: `ERASED_BYTE,
                      status: `STATUS_RESET, sec: `SEC_RESET, pub_stat: `STATUS_RESET,
                      pub_sec: `SEC_RESET, cmd_bus: '{cmd: C_NONE, addr: '0}, default: '0};
        end else begin
            cr_r <= cr_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign dq_o = pins_r.dq;
    assign dq_oe_o = pins_r.oe;
    assign status_o = cr_r.pub_stat;
    assign deep_sleep_o = cr_r.deep;
    assign write_ready_o = cr_r.powered;
    assign arr_rd_o = cr_r.arr_rd;
    assign arr_addr_o = cr_r.arr_addr;
    assign cmd_valid_o = cr_r.cmd_valid;
    assign cmd_o = cr_r.cmd_bus;
    assign prog_valid_o = cr_r.prog_valid;
    assign prog_o = cr_r.prog;

endmodule : sflash_cmd_decoder

// *** tb/sflash_cmd_decoder_sva.sv ***
// assertion checker for the serial flash command decoder, core clock side
// assumes: bound to every decoder instance; link signals seen as levels
`timescale 1ns/10ps
module sflash_cmd_decoder_sva
    import sflash_pkg::*;
#(
    parameter int PUW_CYCLES = 50
) (
    // watched ports
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic cs_n_i,
    input wire logic [3:0] dq_oe_o,
    input wire logic deep_sleep_o,
    input wire logic write_ready_o,
    input wire logic arr_rd_o,
    input wire logic cmd_valid_o,
    input wire cmd_bus_s cmd_o
);
    logic [31:0] up_r;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // saturates so it never wraps back under the threshold
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) up_r <= 32'h0;
        else if (up_r < PUW_CYCLES + 4) up_r <= up_r + 32'h1;
    end
    property p_early; up_r < PUW_CYCLES |-> !write_ready_o; endproperty
    a_early: assert property (p_early) else $error("write ready too early");
    property p_ready; up_r >= PUW_CYCLES |-> write_ready_o; endproperty
    a_ready: assert property (p_ready) else $error("write ready late");
    property p_gate; cmd_valid_o && cmd_o.cmd inside {C_STAT_WR, C_SEC_WR, C_WIPE4K,
        C_WIPE32K, C_WIPE64K, C_CHIP, C_PROG, C_QPROG} |-> write_ready_o; endproperty
    a_gate: assert property (p_gate) else $error("write commit before ready");
    property p_commit; cmd_valid_o |-> cs_n_i && $past(cs_n_i) && $past(cs_n_i, 2); endproperty
    a_commit: assert property (p_commit) else $error("commit while selected");
    property p_idle; cs_n_i && $past(cs_n_i) |-> dq_oe_o == 4'h0; endproperty
    a_idle: assert property (p_idle) else $error("drive while deselected");
    property p_lanes; dq_oe_o inside {4'h0, 4'h2, 4'h3, 4'hf}; endproperty
    a_lanes: assert property (p_lanes) else $error("bad lane enable");
    property p_sleep; $changed(deep_sleep_o) |-> cs_n_i; endproperty
    a_sleep: assert property (p_sleep) else $error("sleep moved in frame");
    property p_quiet; deep_sleep_o |-> !arr_rd_o; endproperty
    a_quiet: assert property (p_quiet) else $error("array read in sleep");
    property p_space; arr_rd_o |=> !arr_rd_o [*8]; endproperty
    a_space: assert property (p_space) else $error("array reads too close");
endmodule : sflash_cmd_decoder_sva

// *** tb/flash_host.sv ***
// host controller model: select, serial clock and data lines
// assumes: clock low and still between frames, device answer read on line 1 or all four
`timescale 1ns/10ps
module flash_host (
    // link
    output logic sclk_o = 1'b0,
    output logic cs_n_o = 1'b1,
    output logic [3:0] dq_o = 4'h0,
    input wire logic [3:0] dq_i
);
    // 160 ns period, under every read clock limit
    task automatic xfer(input logic [7:0] op, input int na, input logic [23:0] a,
        input int nr, input bit q, output logic [15:0] rd);
        logic [31:0] w = {op, a};
        // odd start offset keeps the link out of step with the core clock
        #3.3 cs_n_o = 1'b0;
        for (int i = 31; i > 23 - 8 * na; i -= q ? 4 : 1) begin
            dq_o = q ? w[i -: 4] : {~dq_o[3:1], w[i]};
            #80 sclk_o = 1'b1;
            #80 sclk_o = 1'b0;
        end
        for (int i = 0; i < nr * (q ? 2 : 8); i++) begin
            dq_o = ~dq_o;
            #80 sclk_o = 1'b1;
            rd = q ? {rd[11:0], dq_i} : {rd[14:0], dq_i[1]};
            #80 sclk_o = 1'b0;
        end
        #80 cs_n_o = 1'b1;
        dq_o = ~dq_o;
        #400;
    endtask : xfer
endmodule : flash_host

// *** tb/sflash_cmd_decoder_test.sv ***
// bench for the serial flash command decoder: host model on the link, array stub on the core
// assumes: package, decoder, host model and checker compiled first
`timescale 1ns/10ps
module sflash_cmd_decoder_test;
    import sflash_pkg::*;
    logic core_clk_i = 1'b0, rst_i = 1'b1, fw = 1'b0, busy = 1'b0, seen = 1'b0;
    logic sclk, cs_n, ready, sleep, cv, pv, rdq;
    logic [3:0] hq, dq, oe, lin;
    logic [7:0] st, ad = 8'h00;
    logic [23:0] aa, a;
    logic [15:0] rd;
    cmd_bus_s cb, q[$];
    prog_s pg;
    int err_total = 0, total_checks = 0;
    logic [7:0] ops[5] = '{8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7};
    cmd_e kind[5] = '{C_WIPE4K, C_WIPE32K, C_WIPE64K, C_CHIP, C_CHIP};
    // released lines toggle so a stale value never passes
    assign lin = (oe & dq) | (~oe & {4{core_clk_i}});
    sflash_cmd_decoder #(.PUW_CYCLES(2000)) dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .sclk_i(sclk), .cs_n_i(cs_n), .dq_i(hq), .dq_o(dq), .dq_oe_o(oe),
        .four_wire_command_mode_i(fw), .busy_i(busy), .status_o(st), .deep_sleep_o(sleep),
        .write_ready_o(ready), .arr_rd_o(rdq), .arr_addr_o(aa), .arr_data_i(ad),
        .cmd_valid_o(cv), .cmd_o(cb), .prog_valid_o(pv), .prog_o(pg));
    flash_host host (.sclk_o(sclk), .cs_n_o(cs_n), .dq_o(hq), .dq_i(lin));
    task automatic check(input logic [7:0] got, input logic [7:0] want);
        total_checks++;
        if (got !== want) begin
            err_total++;
            $display("[FAIL] %0t got %h want %h", $time, got, want);
        end
    endtask : check
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up
    initial forever #5 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        ad <= ~aa[7:0];
        if (oe != 4'h0) seen <= 1'b1;
        if (cv === 1'b1) begin
            if (q.size() == 0) check(8'(cb.cmd), 8'(C_NONE));
            else begin
                check(8'(cb.cmd), 8'(q[0].cmd));
                if (q[0].cmd inside {C_WIPE4K, C_WIPE32K, C_WIPE64K, C_PROG}) begin
                    check(cb.addr[23:16], q[0].addr[23:16]);
                    check(cb.addr[7:0], q[0].addr[7:0]);
                end
                void'(q.pop_front());
            end
        end
    end
    initial begin
        void'($urandom(32'h32cf6b5c));
        repeat (20) @(posedge core_clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        check({st[6:0], sleep | ready}, 8'h00);
        host.xfer(8'h06, 0, 0, 0, 0, rd);
        host.xfer(8'h20, 3, 24'h001000, 0, 0, rd);
        for (int n = 0; n < 4000 && ready !== 1'b1; n++) @(posedge core_clk_i);
        check(8'(ready), 8'h01);
        host.xfer(8'h06, 0, 0, 0, 0, rd);
        host.xfer(8'h05, 0, 0, 1, 0, rd);
        check(rd[7:0], 8'h02);
        host.xfer(8'h04, 0, 0, 0, 0, rd);
        host.xfer(8'h05, 0, 0, 1, 0, rd);
        check(rd[7:0], 8'h00);
        for (int i = 0; i < 5; i++) begin
            a = 24'($urandom);
            q.push_back(cmd_bus_s'{kind[i], a});
            host.xfer(8'h06, 0, 0, 0, 0, rd);
            host.xfer(ops[i], i < 3 ? 3 : 0, a, 0, 0, rd);
        end
        check(8'(q.size()), 8'h00);
        host.xfer(8'h03, 3, a, 2, 0, rd);
        check(rd[15:8], ~a[7:0]);
        check(rd[7:0], ~(a[7:0] + 8'h01));
        // the host data phase sends alternating bits, first the inverse of a[0]
        q.push_back(cmd_bus_s'{C_PROG, a});
        host.xfer(8'h06, 0, 0, 0, 0, rd);
        host.xfer(8'h02, 3, a, 1, 0, rd);
        check(pg.data, a[0] ? 8'h55 : 8'haa);
        check(pg.addr[7:0], a[7:0]);
        fw <= 1'b1;
        busy <= 1'($urandom);
        seen <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        host.xfer(8'h9f, 0, 0, 1, 1, rd);
        check(8'(seen), 8'h00);
        host.xfer(8'h05, 0, 0, 1, 1, rd);
        check(rd[7:0], 8'(busy));
        fw <= 1'b0;
        busy <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        q.push_back(cmd_bus_s'{C_SLEEP, a});
        host.xfer(8'hb9, 0, 0, 0, 0, rd);
        check(8'(sleep), 8'h01);
        seen <= 1'b0;
        host.xfer(8'h05, 0, 0, 1, 0, rd);
        check(8'(seen), 8'h00);
        q.push_back(cmd_bus_s'{C_WAKE, a});
        host.xfer(8'hab, 0, 0, 0, 0, rd);
        check(8'(sleep), 8'h00);
        check(8'(q.size()), 8'h00);
        wrap_up();
    end
    initial begin
        #500000;
        err_total++;
        wrap_up();
    end
endmodule : sflash_cmd_decoder_test
bind sflash_cmd_decoder sflash_cmd_decoder_sva #(.PUW_CYCLES(PUW_CYCLES)) chk (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .dq_oe_o(dq_oe_o),
    .deep_sleep_o(deep_sleep_o), .write_ready_o(write_ready_o), .arr_rd_o(arr_rd_o),
    .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o));
